// ---- urxfe_baud.sv ----
/*
  Oversampling rate generator: one-cycle tick every divisor bus clocks.
  Assumes the divisor and enable come from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "urxfe_map.svh"
module urxfe_baud (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Rate control and tick
  urxfe_tick_if.baud bus
);
  import urxfe_pkg::*;

  urxfe_div_t cnt_r;
  logic tick_r;
  logic run;
  logic wrap;

  // Zero divisor stops the generator
  assign run = bus.enable && (bus.divisor != `URXFE_DIV_ZERO);
  assign wrap = (urxfe_div_t'(cnt_r + `URXFE_DIV_ONE) >= bus.divisor);

  always_ff @(posedge i_clk) begin
    if (!i_nrst || !run) begin
      cnt_r <= `URXFE_DIV_ZERO;
    end else if (wrap) begin
      cnt_r <= `URXFE_DIV_ZERO;
    end else begin
      cnt_r <= urxfe_div_t'(cnt_r + `URXFE_DIV_ONE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= run && wrap; // [RQ17]
    end
  end

  assign bus.tick = tick_r; // [RQ1]
endmodule // urxfe_baud
`default_nettype wire

// ---- urxfe_map.svh ----
/*
  Register offsets, field positions, reset values and slot numbers of the
  receive sampling front end. Assumes inclusion by bare name.
*/
`ifndef URXFE_MAP_SVH
`define URXFE_MAP_SVH

// Byte offsets on the register bus
`define URXFE_OFF_CTRL 5'h00
`define URXFE_OFF_STATUS 5'h04
`define URXFE_OFF_DATA 5'h08
`define URXFE_OFF_IRQ_ST 5'h0C
`define URXFE_OFF_IRQ_MASK 5'h10

// Control fields
`define URXFE_CTRL_EN_BIT 16
`define URXFE_DIV_RESET 13'h0004
`define URXFE_DIV_ZERO 13'h0000
`define URXFE_DIV_ONE 13'h0001

// Status fields
`define URXFE_ST_FULL 0
`define URXFE_ST_OVR 1
`define URXFE_ST_NOISE 2
`define URXFE_ST_FERR 3
`define URXFE_ST_BREAK 4

// Interrupt event fields
`define URXFE_EV_CHAR 0
`define URXFE_EV_OVR 1
`define URXFE_EV_FERR 2
`define URXFE_EV_NOISE 3

// Oversampling slots, numbered from one
`define URXFE_SLOT_FIRST 5'h01
`define URXFE_SLOT_VER_A 5'h03
`define URXFE_SLOT_VER_B 5'h05
`define URXFE_SLOT_VER_C 5'h07
`define URXFE_SLOT_MID_A 5'h08
`define URXFE_SLOT_MID_B 5'h09
`define URXFE_SLOT_MID_C 5'h0A
`define URXFE_SLOT_LAST 5'h10

// Frame and edge search
`define URXFE_LAST_DATA_BIT 3'h7
`define URXFE_HIST_HIGH 3'h7
`define URXFE_HIST_RESET 3'h0

`endif

// ---- urxfe_pkg.sv ----
/*
  Types of the receive sampling front end.
  Assumes no surroundings beyond the design files that import it.
*/
package urxfe_pkg;
  typedef logic [4:0] urxfe_addr_t;
  typedef logic [31:0] urxfe_word_t;
  typedef logic [12:0] urxfe_div_t;
  typedef enum logic [1:0] {
    URXFE_IDLE,
    URXFE_START,
    URXFE_DATA,
    URXFE_STOP
  } urxfe_state_e;
endpackage

// ---- urxfe_props.sv ----
/*
  Checker of bus timing, control readback and flag relations.
  Assumes it is bound to urxfe_top, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "urxfe_map.svh"
module urxfe_props (
  // Watched ports
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire urxfe_pkg::urxfe_addr_t I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire urxfe_pkg::urxfe_word_t I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire urxfe_pkg::urxfe_word_t O_AVS_READDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic I_RXD,
  input wire logic O_IRQ
);
  import urxfe_pkg::*;
  logic req, rdone, wdone, st_rd, mask_wr, off, en_r;
  logic [3:0] mask_r;
  urxfe_div_t div_r;
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign rdone = I_AVS_READ & ~O_AVS_WAITREQUEST;
  assign wdone = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
  assign st_rd = rdone & (I_AVS_ADDRESS == `URXFE_OFF_STATUS);
  assign mask_wr = wdone & (I_AVS_ADDRESS == `URXFE_OFF_IRQ_MASK);
  assign off = ~en_r | (div_r == `URXFE_DIV_ZERO);
  // Shadow of control and mask
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      en_r <= 1'b0;
      div_r <= `URXFE_DIV_RESET;
    end else if (wdone && I_AVS_ADDRESS == `URXFE_OFF_CTRL) begin
      if (I_AVS_BYTEENABLE[0]) div_r[7:0] <= I_AVS_WRITEDATA[7:0];
      if (I_AVS_BYTEENABLE[1]) div_r[12:8] <= I_AVS_WRITEDATA[12:8];
      if (I_AVS_BYTEENABLE[2]) en_r <= I_AVS_WRITEDATA[16];
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) mask_r <= 4'h0;
    else if (mask_wr && I_AVS_BYTEENABLE[0]) mask_r <= I_AVS_WRITEDATA[3:0];
  end
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);
  property p_wait_first;
    $rose(req) |-> O_AVS_WAITREQUEST;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_wait_one;
    req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait too long");
  property p_unmapped;
    rdone && I_AVS_ADDRESS > `URXFE_OFF_IRQ_MASK |-> O_AVS_READDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl;
    rdone && I_AVS_ADDRESS == `URXFE_OFF_CTRL |-> O_AVS_READDATA == {15'h0, en_r, 3'h0, div_r};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback");
  property p_mask;
    rdone && I_AVS_ADDRESS == `URXFE_OFF_IRQ_MASK |-> O_AVS_READDATA == {28'h0, mask_r};
  endproperty
  a_mask: assert property (p_mask) else $error("mask readback");
  property p_irq_mask;
    mask_r == 4'h0 |-> !O_IRQ;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
  property p_ovr;
    st_rd |-> !O_AVS_READDATA[1] || O_AVS_READDATA[0];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without full");
  property p_fe;
    st_rd |-> !O_AVS_READDATA[3] || O_AVS_READDATA[0];
  endproperty
  a_fe: assert property (p_fe) else $error("framing error without full");
  property p_brk;
    st_rd |-> !O_AVS_READDATA[4] || O_AVS_READDATA[3];
  endproperty
  a_brk: assert property (p_brk) else $error("break without framing error");
  property p_blk;
    st_rd |-> !(O_AVS_READDATA[3] && O_AVS_READDATA[1]);
  endproperty
  a_blk: assert property (p_blk) else $error("overrun while blocked");
  property p_off;
    off && $past(off) && !$past(mask_wr) |-> !$rose(O_IRQ);
  endproperty
  a_off: assert property (p_off) else $error("event while disabled");
endmodule // urxfe_props
bind urxfe_top urxfe_props i_urxfe_props (.I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
  .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
  .I_RXD(I_RXD), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- urxfe_tb.sv ----
/*
  Self-checking bench: bus tasks, frame model and comparisons.
  Assumes the transmitter model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
`include "urxfe_map.svh"
module tb;
  import urxfe_pkg::*;
  logic clk, nrst, rd, wr, irq, wq, go, busy, rxd;
  urxfe_addr_t addr;
  urxfe_word_t wdata, rdata, q;
  logic [3:0] be, flip;
  logic [9:0] frame;
  logic [15:0] bitc;
  logic [7:0] b;
  bit m_full, m_ovr, m_nf, m_fe, m_brk;
  int err_count, n_checks, t, d, m_data, m_ev, msk;
  urxfe_top i_urxfe_top (.I_REF_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(addr),
    .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
    .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wq), .I_RXD(rxd), .O_IRQ(irq));
  urxfe_tx_model i_urxfe_tx_model (.i_clk(clk), .i_go(go), .i_frame(frame), .i_flip(flip),
    .i_bit_clks(bitc), .o_rxd(rxd), .o_busy(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input urxfe_addr_t a, input urxfe_word_t v);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= v;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Send one frame, then update the model
  task automatic send(input logic [9:0] f, input logic [3:0] fl);
    @(posedge clk);
    frame <= f;
    flip <= fl;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    while (busy) @(negedge clk);
    if (d != 0 && f[0] == 1'b0 && !m_fe) begin
      if (m_full) begin
        m_ovr = 1;
        m_ev |= 2;
      end else begin
        m_full = 1;
        m_data = f[8:1];
        m_nf = (fl != 4'hF);
        m_fe = !f[9];
        m_brk = (f[9:1] == 9'h0);
        m_ev |= 1 | (m_fe ? 4 : 0) | (m_nf ? 8 : 0);
      end
    end
  endtask
  task automatic check_all;
    check("irq", irq, |(m_ev & msk));
    bus(1'b0, `URXFE_OFF_STATUS, '0);
    check("status", q, {m_brk, m_fe, m_nf, m_ovr, m_full});
    bus(1'b0, `URXFE_OFF_DATA, '0);
    if (m_full) check("data", q[7:0], m_data);
    bus(1'b0, `URXFE_OFF_IRQ_ST, '0);
    check("events", q, m_ev);
    bus(1'b0, `URXFE_OFF_STATUS, '0);
    check("cleared", q, 0);
    check("irq off", irq, 0);
    {m_full, m_ovr, m_nf, m_fe, m_brk} = 0;
    m_ev = 0;
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Tests take about six thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
  initial begin
    {nrst, rd, wr, go, m_full, m_ovr, m_nf, m_fe, m_brk} = 0;
    addr = '0;
    wdata = '0;
    be = 4'hF;
    frame = '0;
    flip = 4'hF;
    bitc = 16'h10;
    {err_count, n_checks, d, m_data, m_ev, msk} = 0;
    void'($urandom(22));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i % 2 == 1) bus(1'b1, 5'(4 * i), '1);
      bus(1'b0, 5'(4 * i), '0);
      if (i != 2) check("reset", q, (i == 0) ? 32'(`URXFE_DIV_RESET) : 32'h0);
    end
    for (t = 0; t < 7; t++) begin
      d = (t == 6) ? 0 : 1 + t % 3;
      msk = $urandom & 15;
      b = 8'($urandom);
      bitc = 16'(16 * ((d == 0) ? 1 : d));
      bus(1'b1, `URXFE_OFF_CTRL, 32'h0001_0000 | d);
      bus(1'b1, `URXFE_OFF_IRQ_MASK, msk);
      bus(1'b0, `URXFE_OFF_CTRL, '0);
      check("ctrl", q, 32'h0001_0000 | d);
      bus(1'b0, `URXFE_OFF_IRQ_MASK, '0);
      check("mask", q, msk);
      case (t)
        1: begin
          send({1'b1, b, 1'b0}, 4'hF);
          send({1'b1, ~b, 1'b0}, 4'hF);
        end
        2: begin
          send({1'b0, b | 8'h01, 1'b0}, 4'hF);
          send({1'b1, b, 1'b0}, 4'hF);
        end
        3: send(10'h000, 4'hF);
        4: send(10'h3FF, 4'h0);
        5: send(10'h200, 4'h4);
        default: send({1'b1, b, 1'b0}, 4'hF);
      endcase
      check_all;
    end
    report_and_stop;
  end
endmodule // tb
`default_nettype wire

// ---- urxfe_tick_if.sv ----
/*
  Carrier between the top module and its rate generator: divisor,
  enable and the oversampling tick. Assumes one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface urxfe_tick_if;
  import urxfe_pkg::*;
  urxfe_div_t divisor;
  logic enable;
  logic tick;
  modport baud (input divisor, input enable, output tick);
  modport rx (output divisor, output enable, input tick);
endinterface
`default_nettype wire

// ---- urxfe_top.sv ----
/*
  Receive sampling front end of an asynchronous serial receiver with an
  Avalon-MM register slave and a level interrupt.
  Assumes a 40 MHz clock, a synchronous active-low reset and a serial
  line from another clock domain.
*/
//
// Functional notes
// RQ1: Sample line at sixteen times bit rate.
// RQ2: Falling edge is low after three highs.
// RQ3: Sixteen slots per bit, aligned to edge.
// RQ4: Verify start at slots three, five, seven.
// RQ5: Two low votes synchronise, else search again.
// RQ6: Every bit decided by slots eight-ten majority; the start bit here by the verify vote alone.
// RQ7: Start bit low when verify vote low.
// RQ8: Any disagreeing sample sets noise on transfer.
// RQ9: Every edge realigns the slot counter.
// RQ10: Non-break framing error preloads three highs.
// RQ11: Framing error pending blocks new characters.
// RQ12: Shifter runs on, transfer held off.
// RQ13: All-low frame is break; no preload.
// RQ14: Empty buffer takes character, sets full flag.
// RQ15: Full buffer: overrun set, character dropped.
// RQ16: Low stop bit sets framing error flag.
// RQ17: Tick every divisor clocks; zero disables.
`timescale 1ns/10ps
`default_nettype none
`include "urxfe_map.svh"
module urxfe_top (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  // Avalon-MM slave
  input wire urxfe_pkg::urxfe_addr_t I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire urxfe_pkg::urxfe_word_t I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output var urxfe_pkg::urxfe_word_t O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // Serial line and interrupt
  input wire logic I_RXD,
  output logic O_IRQ
);
  import urxfe_pkg::*;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // Bus handshake
  logic req;
  logic ack_r;
  logic rd_acc;
  logic wr_acc;
  // Registers
  urxfe_div_t div_r;
  logic en_r;
  logic [3:0] mask_r;
  logic [3:0] irq_r;
  logic [7:0] data_r;
  logic full_r;
  logic ovr_r;
  logic nf_r;
  logic fe_r;
  logic brk_r;
  logic arm_r;
  urxfe_word_t rd_mux;
  // Receiver
  logic rxd_s1_r;
  logic rxd_s2_r;
  logic [2:0] hist_r;
  urxfe_state_e state_r;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic [2:0] bit_r;
  logic [2:0] ver_r;
  logic [1:0] mid_r;
  logic [7:0] shift_r;
  logic noise_r;
  logic tick;
  logic samp;
  logic fall;
  logic adv;
  logic lvl;
  logic unan;
  logic done;
  logic brk;
  logic xfer;
  logic ovr_ev;
  logic clr;
  logic [3:0] ev;
  logic [3:0] irq_clr;

  urxfe_tick_if tick_if ();

  urxfe_baud u_baud (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .bus(tick_if.baud)
  );

  assign tick_if.divisor = div_r;
  assign tick_if.enable = en_r;
  assign tick = tick_if.tick;

  // One wait cycle, then the access completes
  assign req = I_AVS_READ | I_AVS_WRITE;
  assign O_AVS_WAITREQUEST = req & ~ack_r;
  assign rd_acc = I_AVS_READ & ack_r;
  assign wr_acc = I_AVS_WRITE & ack_r;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (I_AVS_ADDRESS)
      `URXFE_OFF_CTRL: begin
        rd_mux[12:0] = div_r;
        rd_mux[`URXFE_CTRL_EN_BIT] = en_r;
      end
      `URXFE_OFF_STATUS: begin
        rd_mux[`URXFE_ST_FULL] = full_r;
        rd_mux[`URXFE_ST_OVR] = ovr_r;
        rd_mux[`URXFE_ST_NOISE] = nf_r;
        rd_mux[`URXFE_ST_FERR] = fe_r;
        rd_mux[`URXFE_ST_BREAK] = brk_r;
      end
      `URXFE_OFF_DATA: rd_mux[7:0] = data_r;
      `URXFE_OFF_IRQ_ST: rd_mux[3:0] = irq_r;
      `URXFE_OFF_IRQ_MASK: rd_mux[3:0] = mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, held through the access edge
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS_READ && !ack_r) begin
      O_AVS_READDATA <= rd_mux;
    end
  end

  // Control register and interrupt mask
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      div_r <= `URXFE_DIV_RESET;
      en_r <= 1'b0;
      mask_r <= 4'h0;
    end else if (wr_acc) begin
      if (I_AVS_ADDRESS == `URXFE_OFF_CTRL) begin
        if (I_AVS_BYTEENABLE[0]) begin
          div_r[7:0] <= I_AVS_WRITEDATA[7:0];
        end
        if (I_AVS_BYTEENABLE[1]) begin
          div_r[12:8] <= I_AVS_WRITEDATA[12:8];
        end
        if (I_AVS_BYTEENABLE[2]) begin
          en_r <= I_AVS_WRITEDATA[`URXFE_CTRL_EN_BIT];
        end
      end
      if (I_AVS_ADDRESS == `URXFE_OFF_IRQ_MASK && I_AVS_BYTEENABLE[0]) begin
        mask_r <= I_AVS_WRITEDATA[3:0];
      end
    end
  end

  // Line synchroniser
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= I_RXD;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  assign samp = rxd_s2_r; // [RQ1]
  assign fall = tick & (hist_r == `URXFE_HIST_HIGH) & ~samp; // [RQ2]

  // Edge tick is slot one; an edge past the decision starts the next bit
  assign adv = (slot_r == `URXFE_SLOT_LAST) | (fall & (slot_r > `URXFE_SLOT_MID_C)); // [RQ9]
  assign slot_nxt = fall ? 5'(`URXFE_SLOT_FIRST + 5'h01) : // [RQ9]
                    (slot_r == `URXFE_SLOT_LAST) ? `URXFE_SLOT_FIRST : 5'(slot_r + 5'h01); // [RQ3]

  assign lvl = maj3(mid_r[0], mid_r[1], samp); // [RQ6]
  assign unan = (mid_r[0] == samp) & (mid_r[1] == samp);
  assign done = tick & (state_r == URXFE_STOP) & (slot_r == `URXFE_SLOT_MID_C);
  assign brk = (shift_r == 8'h00) & ~lvl; // [RQ13]

  // Edge-search history
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      hist_r <= `URXFE_HIST_RESET;
    end else if (done && !lvl && !brk) begin
      hist_r <= `URXFE_HIST_HIGH; // [RQ10] [RQ13]
    end else if (tick) begin
      hist_r <= {hist_r[1:0], samp};
    end
  end

  // Frame sequencer
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST || !en_r) begin
      state_r <= URXFE_IDLE;
      slot_r <= `URXFE_SLOT_FIRST;
      bit_r <= 3'h0;
      ver_r <= 3'h0;
      mid_r <= 2'h0;
      shift_r <= 8'h00;
      noise_r <= 1'b0;
    end else if (tick) begin
      unique case (state_r)
        URXFE_IDLE: begin
          if (fall) begin
            state_r <= URXFE_START;
            slot_r <= 5'(`URXFE_SLOT_FIRST + 5'h01); // [RQ3]
            noise_r <= 1'b0;
          end
        end
        URXFE_START, URXFE_DATA, URXFE_STOP: begin
          slot_r <= slot_nxt;
          if (slot_r == `URXFE_SLOT_VER_A) begin
            ver_r[0] <= samp; // [RQ4]
          end
          if (slot_r == `URXFE_SLOT_VER_B) begin
            ver_r[1] <= samp; // [RQ4]
          end
          if (slot_r == `URXFE_SLOT_VER_C) begin
            ver_r[2] <= samp; // [RQ4]
          end
          if (slot_r == `URXFE_SLOT_MID_A) begin
            mid_r[0] <= samp;
          end
          if (slot_r == `URXFE_SLOT_MID_B) begin
            mid_r[1] <= samp;
          end
          if (state_r == URXFE_START && slot_r == `URXFE_SLOT_VER_C &&
              maj3(ver_r[0], ver_r[1], samp)) begin
            state_r <= URXFE_IDLE; // [RQ5]
          end else if (slot_r == `URXFE_SLOT_MID_C) begin
            unique case (state_r)
              URXFE_START: begin
                // Start stays low whatever the mid samples say
                noise_r <= noise_r | (|ver_r) | mid_r[0] | mid_r[1] | samp; // [RQ7] [RQ8]
              end
              URXFE_DATA: begin
                shift_r <= {lvl, shift_r[7:1]}; // [RQ6] [RQ12]
                noise_r <= noise_r | ~unan; // [RQ8]
              end
              URXFE_STOP: begin
                state_r <= URXFE_IDLE;
              end
              URXFE_IDLE: begin
                state_r <= URXFE_IDLE;
              end
            endcase
          end else if (adv && state_r == URXFE_START) begin
            state_r <= URXFE_DATA;
            bit_r <= 3'h0;
          end else if (adv && state_r == URXFE_DATA) begin
            if (bit_r == `URXFE_LAST_DATA_BIT) begin
              state_r <= URXFE_STOP;
            end else begin
              bit_r <= 3'(bit_r + 3'h1);
            end
          end
        end
      endcase
    end
  end

  // Character hand-over into the buffer
  assign xfer = done & ~fe_r & ~full_r; // [RQ11] [RQ14]
  assign ovr_ev = done & ~fe_r & full_r; // [RQ15]
  assign clr = rd_acc & (I_AVS_ADDRESS == `URXFE_OFF_DATA) & arm_r;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      data_r <= 8'h00;
    end else if (xfer) begin
      data_r <= shift_r; // [RQ14]
    end
  end

  // Flags: set wins over the two-step clear
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      full_r <= 1'b0;
      ovr_r <= 1'b0;
      nf_r <= 1'b0;
      fe_r <= 1'b0;
      brk_r <= 1'b0;
    end else if (xfer) begin
      full_r <= 1'b1; // [RQ14]
      nf_r <= noise_r | ~unan; // [RQ8]
      fe_r <= ~lvl; // [RQ16]
      brk_r <= brk; // [RQ13]
      ovr_r <= ovr_r & ~clr;
    end else begin
      full_r <= full_r & ~clr;
      nf_r <= nf_r & ~clr;
      fe_r <= fe_r & ~clr;
      brk_r <= brk_r & ~clr;
      ovr_r <= ovr_ev | (ovr_r & ~clr); // [RQ15]
    end
  end

  // Status read with a flag up arms the data-read clear
  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      arm_r <= 1'b0;
    end else if (rd_acc && I_AVS_ADDRESS == `URXFE_OFF_STATUS) begin
      arm_r <= |O_AVS_READDATA[`URXFE_ST_BREAK:`URXFE_ST_FULL];
    end else if (clr) begin
      arm_r <= 1'b0;
    end
  end

  // Sticky interrupt events, cleared only where the read showed them
  always_comb begin
    ev = 4'h0;
    ev[`URXFE_EV_CHAR] = xfer;
    ev[`URXFE_EV_OVR] = ovr_ev;
    ev[`URXFE_EV_FERR] = xfer & ~lvl;
    ev[`URXFE_EV_NOISE] = xfer & (noise_r | ~unan);
  end

  assign irq_clr = (rd_acc && I_AVS_ADDRESS == `URXFE_OFF_IRQ_ST) ?
                   O_AVS_READDATA[3:0] : 4'h0;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_NRST) begin
      irq_r <= 4'h0;
    end else begin
      irq_r <= ev | (irq_r & ~irq_clr);
    end
  end

  assign O_IRQ = |(irq_r & mask_r);
endmodule // urxfe_top
`default_nettype wire

// ---- urxfe_tx_model.sv ----
/*
  Remote serial transmitter: start, eight data, stop, then ten idle bits.
  Assumes bit_clks is a multiple of sixteen; one bit may carry a glitch.
*/
`timescale 1ns/10ps
`default_nettype none
module urxfe_tx_model (
  // Clock and request
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [9:0] i_frame,
  input wire logic [3:0] i_flip,
  input wire logic [15:0] i_bit_clks,
  // Line and status
  output logic o_rxd,
  output logic o_busy
);
  logic [9:0] frame_r;
  logic [3:0] flip_r;
  int cnt_r, bitn, off, d;
  initial o_busy = 1'b0;
  always @(posedge i_clk) begin
    if (!o_busy && i_go) begin
      o_busy <= 1'b1;
      cnt_r <= 0;
      frame_r <= i_frame;
      flip_r <= i_flip;
    end else if (o_busy) begin
      cnt_r <= cnt_r + 1;
      if (cnt_r == 20 * i_bit_clks - 1) o_busy <= 1'b0;
    end
  end
  // Idle high; glitch spans the ninth sixteenth of the bit
  always_comb begin
    bitn = cnt_r / i_bit_clks;
    off = cnt_r % i_bit_clks;
    d = i_bit_clks / 16;
    o_rxd = 1'b1;
    if (o_busy && bitn < 10) begin
      o_rxd = frame_r[bitn] ^ (bitn == flip_r && off >= 8 * d && off < 9 * d);
    end
  end
endmodule // urxfe_tx_model
`default_nettype wire
